// File: rtl/hpgb_defines.vh
// Functional notes
// - Push-pull pin drives ground for latch 0 and supply for latch 1.
// - Open-drain pin drives low for latch 0 and floats for latch 1.
// - Mode bit 0 selects open-drain, 1 selects push-pull, per pin.
// - Reset clears every output-mode register, so all pins start open-drain.
// - Weak pull-ups default on; global disable bit switches all of them off.
// - Pull-up is turned off on any pin being driven low.
// - Active external memory access overrides latch contents on its pins.
// - Memory access keeps modes, but off-chip reads release data-bus drivers.
// - Latch writes drive pins; data register reads return pin levels.
// - Three-pin port implements bits 7 to 5; its unused data-register bits read as one.
// - Three-pin port bits 7,6,5 carry write strobe, read strobe, latch enable.
// - First eight-pin port carries address 15:8 in non-multiplexed mode.
// - Second port carries address 15:8 multiplexed, address 7:0 non-multiplexed.
// - Third port carries address/data multiplexed, data 7:0 non-multiplexed.
// - Data registers and input paths stay present even without package pins.
// - All these registers decode only while the page selector holds page F.
// - Read phase of read-modify-write returns latch contents, not pin levels.
`ifndef HPGB_DEFINES_VH
`define HPGB_DEFINES_VH

// Register page that holds the whole bank.
`define HPGB_PAGE_F 8'h0F

// Register addresses within that page.
`define HPGB_ADDR_P4_MODE 8'h9C
`define HPGB_ADDR_P5_MODE 8'h9D
`define HPGB_ADDR_P6_MODE 8'h9E
`define HPGB_ADDR_P7_MODE 8'h9F
`define HPGB_ADDR_P4_LATCH 8'hC8
`define HPGB_ADDR_P5_LATCH 8'hD8
`define HPGB_ADDR_P6_LATCH 8'hE8
`define HPGB_ADDR_P7_LATCH 8'hF8

// Reset values.
`define HPGB_LATCH_RST 8'hFF
`define HPGB_MODE_RST 8'h00

// Implemented bits of each port and the fill for the absent three-pin port bits.
`define HPGB_P4_IMPL 8'hE0
`define HPGB_FULL_IMPL 8'hFF
`define HPGB_P4_FILL 5'h1F
`define HPGB_BYTE_ZERO 8'h00

`endif

// File: rtl/hpgb_bank.v
`timescale 1ns/100ps
`include "hpgb_defines.vh"

module hpgb_bank
(
    // Clock, reset and clock enable.
    input wire CLOCK_I,
    input wire RST_I,
    input wire CE_I,
    // Special-function-register access.
    input wire [7:0] SFR_ADDR_I,
    input wire [7:0] SFR_PAGE_I,
    input wire [7:0] SFR_WDATA_I,
    input wire SFR_WE_I,
    input wire SFR_RE_I,
    input wire SFR_RMW_I,
    output reg [7:0] SFR_RDATA_O,
    // Crossbar configuration.
    input wire PULLUP_GLOBAL_DISABLE_I,
    // External memory interface.
    input wire EXTERNAL_MEMORY_INTERFACE_ACTIVE_I,
    input wire EXTERNAL_MEMORY_INTERFACE_MUX_I,
    input wire EXTERNAL_MEMORY_INTERFACE_READ_I,
    input wire EXTERNAL_MEMORY_INTERFACE_WR_N_I,
    input wire EXTERNAL_MEMORY_INTERFACE_RD_N_I,
    input wire EXTERNAL_MEMORY_INTERFACE_ALE_I,
    input wire [15:0] EXTERNAL_MEMORY_INTERFACE_ADDR_I,
    input wire [7:0] EXTERNAL_MEMORY_INTERFACE_WDATA_I,
    // Three-pin port, pins 7 to 5.
    input wire [2:0] PORT4_IN_I,
    output wire [2:0] PORT4_OUT_O,
    output wire [2:0] PORT4_OE_O,
    output wire [2:0] PORT4_PULLUP_O,
    // First eight-pin port.
    input wire [7:0] PORT5_IN_I,
    output wire [7:0] PORT5_OUT_O,
    output wire [7:0] PORT5_OE_O,
    output wire [7:0] PORT5_PULLUP_O,
    // Second eight-pin port.
    input wire [7:0] PORT6_IN_I,
    output wire [7:0] PORT6_OUT_O,
    output wire [7:0] PORT6_OE_O,
    output wire [7:0] PORT6_PULLUP_O,
    // Third eight-pin port.
    input wire [7:0] PORT7_IN_I,
    output wire [7:0] PORT7_OUT_O,
    output wire [7:0] PORT7_OE_O,
    output wire [7:0] PORT7_PULLUP_O
);

////////////////////////////////////////////////////////////////////////////////
// Register decode.

wire page_ok;
reg [3:0] lat_we;
reg [3:0] mod_we;
wire [31:0] impl;
wire [31:0] lat_q;
wire [31:0] mod_q;

// Nothing in the bank answers outside page F.
assign page_ok = (SFR_PAGE_I == `HPGB_PAGE_F);

// Implemented-bit mask, one byte per port, three-pin port lowest.
assign impl = {`HPGB_FULL_IMPL, `HPGB_FULL_IMPL, `HPGB_FULL_IMPL, `HPGB_P4_IMPL};

// Write strobes for latches and mode registers.
always @*
begin
    lat_we = 4'h0;
    mod_we = 4'h0;
    if (!(SFR_WE_I && page_ok))
    begin
        lat_we = 4'h0;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P4_LATCH)
    begin
        lat_we = 4'h1;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P5_LATCH)
    begin
        lat_we = 4'h2;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P6_LATCH)
    begin
        lat_we = 4'h4;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P7_LATCH)
    begin
        lat_we = 4'h8;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P4_MODE)
    begin
        mod_we = 4'h1;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P5_MODE)
    begin
        mod_we = 4'h2;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P6_MODE)
    begin
        mod_we = 4'h4;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P7_MODE)
    begin
        mod_we = 4'h8;
    end
end

////////////////////////////////////////////////////////////////////////////////
// External memory interface takeover.

reg [31:0] external_memory_interface_own;
reg [31:0] external_memory_interface_val;
reg [31:0] external_memory_interface_rd_off;
wire external_memory_interface_addr_phase;

// In multiplexed mode the shared byte carries address while the latch enable is high.
assign external_memory_interface_addr_phase = EXTERNAL_MEMORY_INTERFACE_MUX_I && EXTERNAL_MEMORY_INTERFACE_ALE_I;

// Which pins the interface owns and what it puts on them.
always @*
begin
    external_memory_interface_own = 32'h0000_0000;
    external_memory_interface_val = 32'hFFFF_FFFF;
    external_memory_interface_rd_off = 32'h0000_0000;
    if (EXTERNAL_MEMORY_INTERFACE_ACTIVE_I)
    begin
        // Strobes and latch enable on the three-pin port.
        external_memory_interface_own[7:5] = 3'h7;
        external_memory_interface_val[7:5] = {EXTERNAL_MEMORY_INTERFACE_WR_N_I, EXTERNAL_MEMORY_INTERFACE_RD_N_I, EXTERNAL_MEMORY_INTERFACE_ALE_I};
        // Upper address only in non-multiplexed mode.
        if (!EXTERNAL_MEMORY_INTERFACE_MUX_I)
        begin
            external_memory_interface_own[15:8] = 8'hFF;
            external_memory_interface_val[15:8] = EXTERNAL_MEMORY_INTERFACE_ADDR_I[15:8];
        end
        // Second port: upper or lower address by mode.
        external_memory_interface_own[23:16] = 8'hFF;
        external_memory_interface_val[23:16] = EXTERNAL_MEMORY_INTERFACE_MUX_I ? EXTERNAL_MEMORY_INTERFACE_ADDR_I[15:8] : EXTERNAL_MEMORY_INTERFACE_ADDR_I[7:0];
        // Third port: shared address and data, or plain data.
        external_memory_interface_own[31:24] = 8'hFF;
        external_memory_interface_val[31:24] = external_memory_interface_addr_phase ? EXTERNAL_MEMORY_INTERFACE_ADDR_I[7:0] : EXTERNAL_MEMORY_INTERFACE_WDATA_I;
        // A read must leave the data bus free for the memory to answer.
        if (EXTERNAL_MEMORY_INTERFACE_READ_I && !external_memory_interface_addr_phase)
        begin
            external_memory_interface_rd_off[31:24] = 8'hFF;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Latches, modes and pin drivers, one copy per port.

wire [31:0] drv_out_q;
wire [31:0] drv_oe_q;
wire [31:0] drv_pu_q;
wire [31:0] val;
wire [31:0] oe_d;
wire [31:0] pu_d;

genvar gp;
generate
    for (gp = 0; gp < 4; gp = gp + 1)
    begin : g_port
        // Each port keeps its own byte registers, so no register is driven by two processes.
        reg [7:0] lat_b_q;
        reg [7:0] mod_b_q;
        reg [7:0] out_b_q;
        reg [7:0] oe_b_q;
        reg [7:0] pu_b_q;

        // Unimplemented latch bits hold one and unimplemented mode bits hold zero.
        always @(posedge CLOCK_I or posedge RST_I)
        begin
            if (RST_I)
            begin
                lat_b_q <= `HPGB_LATCH_RST;
                mod_b_q <= `HPGB_MODE_RST;
            end
            else if (CE_I)
            begin
                if (lat_we[gp])
                begin
                    lat_b_q <= (SFR_WDATA_I & impl[gp*8 +: 8])
                        | ~impl[gp*8 +: 8];
                end
                if (mod_we[gp])
                begin
                    mod_b_q <= SFR_WDATA_I & impl[gp*8 +: 8];
                end
            end
        end

        // The bank-wide views are plain wires, one byte slice per port.
        assign lat_q[gp*8 +: 8] = lat_b_q;
        assign mod_q[gp*8 +: 8] = mod_b_q;

        // Level to present: the interface wins over the latch while it owns the pin.
        assign val[gp*8 +: 8] = (external_memory_interface_own[gp*8 +: 8] & external_memory_interface_val[gp*8 +: 8])
            | (~external_memory_interface_own[gp*8 +: 8] & lat_q[gp*8 +: 8]);
        // Zero drives and one drives only in push-pull, except on a data bus released for a read. Mode is never changed here.
        assign oe_d[gp*8 +: 8] = (mod_q[gp*8 +: 8] | ~val[gp*8 +: 8])
            & ~external_memory_interface_rd_off[gp*8 +: 8];
        // Pull-up is off globally, or on a pin that this bank pulls low.
        assign pu_d[gp*8 +: 8] = {8{~PULLUP_GLOBAL_DISABLE_I}}
            & ~(oe_d[gp*8 +: 8] & ~val[gp*8 +: 8]);

        // Pin drive is registered so every pin output comes from a flip-flop.
        always @(posedge CLOCK_I or posedge RST_I)
        begin
            if (RST_I)
            begin
                out_b_q <= `HPGB_LATCH_RST;
                oe_b_q <= `HPGB_BYTE_ZERO;
                pu_b_q <= `HPGB_LATCH_RST;
            end
            else if (CE_I)
            begin
                out_b_q <= val[gp*8 +: 8];
                oe_b_q <= oe_d[gp*8 +: 8] & impl[gp*8 +: 8];
                pu_b_q <= pu_d[gp*8 +: 8] & impl[gp*8 +: 8];
            end
        end

        // Driver flops gathered into the bank-wide pin vectors.
        assign drv_out_q[gp*8 +: 8] = out_b_q;
        assign drv_oe_q[gp*8 +: 8] = oe_b_q;
        assign drv_pu_q[gp*8 +: 8] = pu_b_q;
    end
endgenerate

// Pin outputs, taken straight from the driver flip-flops.
assign PORT4_OUT_O = drv_out_q[7:5];
assign PORT4_OE_O = drv_oe_q[7:5];
assign PORT4_PULLUP_O = drv_pu_q[7:5];
assign PORT5_OUT_O = drv_out_q[15:8];
assign PORT5_OE_O = drv_oe_q[15:8];
assign PORT5_PULLUP_O = drv_pu_q[15:8];
assign PORT6_OUT_O = drv_out_q[23:16];
assign PORT6_OE_O = drv_oe_q[23:16];
assign PORT6_PULLUP_O = drv_pu_q[23:16];
assign PORT7_OUT_O = drv_out_q[31:24];
assign PORT7_OE_O = drv_oe_q[31:24];
assign PORT7_PULLUP_O = drv_pu_q[31:24];

////////////////////////////////////////////////////////////////////////////////
// Register read.

wire [31:0] pin_lvl;
reg [7:0] rd_d;

// Input paths stay live even when a package leaves the pins unbonded.
assign pin_lvl = {PORT7_IN_I, PORT6_IN_I, PORT5_IN_I, PORT4_IN_I, `HPGB_P4_FILL};

// Data reads return pin levels, except in the read phase of read-modify-write,
// where the latch is returned so a bit held low by another driver is not lost.
always @*
begin
    rd_d = `HPGB_BYTE_ZERO;
    if (!page_ok)
    begin
        rd_d = `HPGB_BYTE_ZERO;
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P4_LATCH)
    begin
        rd_d = SFR_RMW_I ? lat_q[7:0] : pin_lvl[7:0];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P5_LATCH)
    begin
        rd_d = SFR_RMW_I ? lat_q[15:8] : pin_lvl[15:8];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P6_LATCH)
    begin
        rd_d = SFR_RMW_I ? lat_q[23:16] : pin_lvl[23:16];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P7_LATCH)
    begin
        rd_d = SFR_RMW_I ? lat_q[31:24] : pin_lvl[31:24];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P4_MODE)
    begin
        rd_d = mod_q[7:0];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P5_MODE)
    begin
        rd_d = mod_q[15:8];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P6_MODE)
    begin
        rd_d = mod_q[23:16];
    end
    else if (SFR_ADDR_I == `HPGB_ADDR_P7_MODE)
    begin
        rd_d = mod_q[31:24];
    end
end

// Read data is captured on the read strobe and held until the next one.
always @(posedge CLOCK_I or posedge RST_I)
begin
    if (RST_I)
    begin
        SFR_RDATA_O <= `HPGB_BYTE_ZERO;
    end
    else if (CE_I && SFR_RE_I)
    begin
        SFR_RDATA_O <= rd_d;
    end
end

endmodule // hpgb_bank

// File: test/hpgb_pin_model.sv
`timescale 1ns/100ps
// Far side of one port: resolves each pin from the bank, an external part and the pull-up.
module hpgb_pin_model #(parameter W = 8)
(
    // Bank drivers.
    input wire [W-1:0] oe_i,
    input wire [W-1:0] out_i,
    input wire [W-1:0] pu_i,
    // External part.
    input wire [W-1:0] ext_en_i,
    input wire [W-1:0] ext_i,
    // Pin level.
    output wire [W-1:0] pin_o
);
    // A wire nobody holds reads high with its pull-up, else the inverse of the last bank level, so a stale value never passes.
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
        | (~oe_i & ~ext_en_i & (pu_i | ~out_i));
endmodule // hpgb_pin_model

// File: test/hpgb_bank_props.sv
`timescale 1ns/100ps
module hpgb_bank_props
(
    // Clock and reset.
    input wire CLOCK_I,
    input wire RST_I,
    input wire CE_I,
    // Register bus.
    input wire [7:0] SFR_PAGE_I,
    input wire SFR_RE_I,
    input wire [7:0] SFR_RDATA_O,
    // Pull-up control and memory interface.
    input wire PULLUP_GLOBAL_DISABLE_I,
    input wire EXTERNAL_MEMORY_INTERFACE_ACTIVE_I,
    input wire EXTERNAL_MEMORY_INTERFACE_MUX_I,
    input wire EXTERNAL_MEMORY_INTERFACE_READ_I,
    input wire EXTERNAL_MEMORY_INTERFACE_ALE_I,
    input wire [15:0] EXTERNAL_MEMORY_INTERFACE_ADDR_I,
    input wire [7:0] EXTERNAL_MEMORY_INTERFACE_WDATA_I,
    // Pins.
    input wire [7:0] PORT5_OUT_O,
    input wire [7:0] PORT5_OE_O,
    input wire [7:0] PORT5_PULLUP_O,
    input wire [7:0] PORT6_OUT_O,
    input wire [7:0] PORT7_OUT_O,
    input wire [7:0] PORT7_OE_O
);
    // Address halves as plain signals, so the past value is taken of a whole signal.
    wire [7:0] addr_hi = EXTERNAL_MEMORY_INTERFACE_ADDR_I[15:8];
    wire [7:0] addr_lo = EXTERNAL_MEMORY_INTERFACE_ADDR_I[7:0];
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin driver relations.
    a_low_driven: assert property ((~PORT5_OE_O & ~PORT5_OUT_O) == 8'h00)
        else $error("low level left undriven");
    a_no_fight: assert property ((PORT5_OE_O & ~PORT5_OUT_O & PORT5_PULLUP_O) == 8'h00)
        else $error("pull-up on while driving low");
    a_pullup_off: assert property (CE_I && PULLUP_GLOBAL_DISABLE_I |=> PORT5_PULLUP_O == 8'h00)
        else $error("pull-up still on after disable");
    // Memory interface takeover, one cycle after the request.
    a_addr_high: assert property (CE_I && EXTERNAL_MEMORY_INTERFACE_ACTIVE_I && !EXTERNAL_MEMORY_INTERFACE_MUX_I |=> PORT5_OUT_O == $past(addr_hi))
        else $error("port5 address wrong");
    a_addr_mid: assert property (CE_I && EXTERNAL_MEMORY_INTERFACE_ACTIVE_I |=>
        PORT6_OUT_O == ($past(EXTERNAL_MEMORY_INTERFACE_MUX_I) ? $past(addr_hi) : $past(addr_lo)))
        else $error("port6 address wrong");
    a_data_out: assert property (CE_I && EXTERNAL_MEMORY_INTERFACE_ACTIVE_I && !EXTERNAL_MEMORY_INTERFACE_MUX_I && !EXTERNAL_MEMORY_INTERFACE_READ_I |=>
        PORT7_OUT_O == $past(EXTERNAL_MEMORY_INTERFACE_WDATA_I))
        else $error("port7 data wrong");
    a_read_release: assert property (CE_I && EXTERNAL_MEMORY_INTERFACE_ACTIVE_I && EXTERNAL_MEMORY_INTERFACE_READ_I &&
        !(EXTERNAL_MEMORY_INTERFACE_MUX_I && EXTERNAL_MEMORY_INTERFACE_ALE_I) |=> PORT7_OE_O == 8'h00)
        else $error("data bus driven during read");
    // Register bus refusal.
    a_offpage_zero: assert property (CE_I && SFR_RE_I && SFR_PAGE_I != 8'h0F |=> SFR_RDATA_O == 8'h00)
        else $error("off-page read not zero");
    c_ext_read: cover property (EXTERNAL_MEMORY_INTERFACE_ACTIVE_I && EXTERNAL_MEMORY_INTERFACE_READ_I);
    c_offpage: cover property (SFR_RE_I && SFR_PAGE_I != 8'h0F);
    c_pud: cover property (PULLUP_GLOBAL_DISABLE_I);
endmodule // hpgb_bank_props

bind hpgb_bank hpgb_bank_props hpgb_bank_props_i (.CLOCK_I, .RST_I, .CE_I, .SFR_PAGE_I, .SFR_RE_I,
    .SFR_RDATA_O, .PULLUP_GLOBAL_DISABLE_I, .EXTERNAL_MEMORY_INTERFACE_ACTIVE_I, .EXTERNAL_MEMORY_INTERFACE_MUX_I, .EXTERNAL_MEMORY_INTERFACE_READ_I, .EXTERNAL_MEMORY_INTERFACE_ALE_I,
    .EXTERNAL_MEMORY_INTERFACE_ADDR_I, .EXTERNAL_MEMORY_INTERFACE_WDATA_I, .PORT5_OUT_O, .PORT5_OE_O, .PORT5_PULLUP_O, .PORT6_OUT_O,
    .PORT7_OUT_O, .PORT7_OE_O);

// File: test/test_high_port_gpio_bank.sv
`timescale 1ns/100ps
module test_high_port_gpio_bank;
    // Rows: latch address, mode address, mode, latch value, then expected pin output,
    // output enable, pull-up and read-back; port 4 output, enable and pull-up show only pins 7 to 5.
    localparam [255:0] ROWS = {64'hC89CE05F40E0405F, 64'hD89D000F0FF00F0F,
        64'hE89EFF0000FF0000, 64'hF89FA55A5AA55A5A};
    reg clk = 1'b0, rst = 1'b1, ce = 1'b1, we = 1'b0, re = 1'b0, rmw = 1'b0, pud = 1'b0;
    reg ea = 1'b0, emux = 1'b0, erd = 1'b0, ewr_n = 1'b1, erd_n = 1'b1, eale = 1'b0;
    reg [7:0] addr = 8'h00, page = 8'h0F, wd = 8'h00, ewd = 8'h00, x7 = 8'h00, x7en = 8'h00;
    reg [7:0] x5en = 8'h00;
    reg [15:0] eadr = 16'h0000;
    reg [7:0] a, b, md, v, o, e, p, xo, xe, xp, xl;
    wire [7:0] rd, p5i, p5o, p5e, p5p, p6i, p6o, p6e, p6p, p7i, p7o, p7e, p7p;
    wire [2:0] p4i, p4o, p4e, p4p;
    integer miscompares = 0, num_checks = 0, k;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz.
    initial forever #2.5 clk = ~clk;
    // Bank and its pins; ports 5 and 7 meet an external part.
    hpgb_bank hpgb_bank_i (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .SFR_ADDR_I(addr),
        .SFR_PAGE_I(page), .SFR_WDATA_I(wd), .SFR_WE_I(we), .SFR_RE_I(re), .SFR_RMW_I(rmw),
        .SFR_RDATA_O(rd), .PULLUP_GLOBAL_DISABLE_I(pud), .EXTERNAL_MEMORY_INTERFACE_ACTIVE_I(ea), .EXTERNAL_MEMORY_INTERFACE_MUX_I(emux),
        .EXTERNAL_MEMORY_INTERFACE_READ_I(erd), .EXTERNAL_MEMORY_INTERFACE_WR_N_I(ewr_n), .EXTERNAL_MEMORY_INTERFACE_RD_N_I(erd_n), .EXTERNAL_MEMORY_INTERFACE_ALE_I(eale),
        .EXTERNAL_MEMORY_INTERFACE_ADDR_I(eadr), .EXTERNAL_MEMORY_INTERFACE_WDATA_I(ewd), .PORT4_IN_I(p4i), .PORT4_OUT_O(p4o),
        .PORT4_OE_O(p4e), .PORT4_PULLUP_O(p4p), .PORT5_IN_I(p5i), .PORT5_OUT_O(p5o),
        .PORT5_OE_O(p5e), .PORT5_PULLUP_O(p5p), .PORT6_IN_I(p6i), .PORT6_OUT_O(p6o),
        .PORT6_OE_O(p6e), .PORT6_PULLUP_O(p6p), .PORT7_IN_I(p7i), .PORT7_OUT_O(p7o),
        .PORT7_OE_O(p7e), .PORT7_PULLUP_O(p7p));
    hpgb_pin_model #(.W(3)) m4 (.oe_i(p4e), .out_i(p4o), .pu_i(p4p), .ext_en_i(3'h0),
        .ext_i(3'h0), .pin_o(p4i));
    hpgb_pin_model m5 (.oe_i(p5e), .out_i(p5o), .pu_i(p5p), .ext_en_i(x5en), .ext_i(8'h00),
        .pin_o(p5i));
    hpgb_pin_model m6 (.oe_i(p6e), .out_i(p6o), .pu_i(p6p), .ext_en_i(8'h00), .ext_i(8'h00),
        .pin_o(p6i));
    hpgb_pin_model m7 (.oe_i(p7e), .out_i(p7o), .pu_i(p7p), .ext_en_i(x7en), .ext_i(x7),
        .pin_o(p7i));
    ////////////////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input [7:0] g, input [7:0] x);
    begin
        num_checks++;
        if (g !== x)
        begin
            miscompares++;
            $display("ERROR %0s expected %h seen %h", n, x, g);
        end
    end
    endtask
    // One write, taken at the second edge.
    task wr(input [7:0] ra, input [7:0] d);
    begin
        @(posedge clk);
        addr <= ra;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    end
    endtask
    // One read; data is settled just after the edge that takes it.
    task rdc(input [7:0] ra, input r, input [7:0] x, input string n);
    begin
        @(posedge clk);
        addr <= ra;
        rmw <= r;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        rmw <= 1'b0;
        #1 chk(n, rd, x);
    end
    endtask
    // Two edges: the first loads the registered pin outputs from the inputs, the second is spare.
    task settle;
    begin
        @(posedge clk);
        @(posedge clk);
        #1;
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the hundred or so cycles the run needs.
    initial
    begin
        #20000;
        miscompares++;
        end_sim;
    end
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 4; k++)
        begin
            {a, b, md, v, xo, xe, xp, xl} = ROWS[255-64*k -: 64];
            wr(b, md);
            wr(a, v);
            @(posedge clk);
            #1;
            o = a == 8'hC8 ? {p4o, 5'h00} : a == 8'hD8 ? p5o : a == 8'hE8 ? p6o : p7o;
            e = a == 8'hC8 ? {p4e, 5'h00} : a == 8'hD8 ? p5e : a == 8'hE8 ? p6e : p7e;
            p = a == 8'hC8 ? {p4p, 5'h00} : a == 8'hD8 ? p5p : a == 8'hE8 ? p6p : p7p;
            chk("out", o, xo);
            chk("oe", e, xe);
            chk("pullup", p, xp);
            rdc(b, 1'b0, md, "mode");
            rdc(a, 1'b1, xl, "latch");
            rdc(a, 1'b0, xl, "pins");
            $display("row %0d done", k);
        end
        // Off page, unmapped and frozen accesses leave port 5 at 0x0F.
        @(posedge clk);
        page <= 8'h0E;
        wr(8'hD8, 8'h00);
        rdc(8'hD8, 1'b1, 8'h00, "offpage");
        @(posedge clk);
        page <= 8'h0F;
        ce <= 1'b0;
        wr(8'hD8, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        rdc(8'hD8, 1'b1, 8'h0F, "latch");
        rdc(8'h9B, 1'b0, 8'h00, "unmapped");
        // An outside part pulls a released port 5 pin low: pins read low, the latch does not.
        @(posedge clk);
        x5en <= 8'h01;
        rdc(8'hD8, 1'b0, 8'h0E, "extlow");
        rdc(8'hD8, 1'b1, 8'h0F, "rmwlatch");
        @(posedge clk);
        x5en <= 8'h00;
        $display("refusals done");
        // Port 7 as an input sensed through a released pin.
        wr(8'h9F, 8'h00);
        wr(8'hF8, 8'hFF);
        @(posedge clk);
        x7en <= 8'hFF;
        x7 <= 8'h3C;
        rdc(8'hF8, 1'b0, 8'h3C, "input");
        @(posedge clk);
        pud <= 1'b1;
        settle;
        chk("pudis", p5p, 8'h00);
        $display("input and pull-up done");
        // External write, non-multiplexed.
        @(posedge clk);
        pud <= 1'b0;
        {ea, emux, erd, ewr_n, erd_n, eale} <= 6'h23;
        eadr <= 16'h1234;
        ewd <= 8'hC3;
        settle;
        chk("addrhi", p5o, 8'h12);
        chk("addrlo", p6o, 8'h34);
        chk("data", p7o, 8'hC3);
        chk("strobes", {5'h00, p4o}, 8'h03);
        // External read, multiplexed, latch enable low.
        @(posedge clk);
        {ea, emux, erd, ewr_n, erd_n, eale} <= 6'h3C;
        settle;
        chk("release", p7e, 8'h00);
        chk("addrmux", p6o, 8'h12);
        chk("keep5", p5o, 8'h0F);
        chk("strobes", {5'h00, p4o}, 8'h04);
        @(posedge clk);
        ea <= 1'b0;
        rdc(8'h9F, 1'b0, 8'h00, "mode");
        rdc(8'h9E, 1'b0, 8'hFF, "mode6");
        $display("memory interface done");
        // Second reset in mid-run.
        @(posedge clk);
        rst <= 1'b1;
        settle;
        chk("rstoe", p5e, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        rdc(8'h9D, 1'b0, 8'h00, "rstmode");
        rdc(8'hD8, 1'b1, 8'hFF, "rstlatch");
        $display("reset done");
        end_sim;
    end
endmodule // test_high_port_gpio_bank
